// ===== memory_map_regs.vh
// constants for the memory map decoder: register offsets, fields, reset values, map
// assumes a 16-bit word-addressed cpu and a 32-bit classic wishbone register bus
//
// Operation
// [RL1] program, data and i/o spaces are 64K words each, decoded separately.
// [RL2] top of data space, 256 to 32K words, becomes external global memory.
// [RL3] global memory accesses request the bus and wait for grant first.
// [RL4] data words 0h to 5Fh hold registers or reserved space, never ram.
// [RL5] two enable bits place the single access ram in program, data or both.
// [RL6] single access ram at data 800h and program 8000h, one shared array.
// [RL7] boot pin high at reset selects microprocessor mode, external fetch from zero.
// [RL8] boot pin level latched into mode bit 0, software may change it.
// [RL9] mode bit cleared maps program low half to on-chip flash.
// [RL10] select bit clear puts block zero in data at 100h and 200h ranges.
// [RL11] alias address bit is ignored so both ranges reach the same word.
// [RL12] select bit set moves block zero into program FE00h and FF00h ranges.
// [RL13] block one always in data at 300h and 400h ranges.
// [RL14] 32-word block two always in data at 60h to 7Fh.
// [RL15] program 0h to 7FFFh: flash in microcontroller mode, external otherwise.
// [RL16] every address no block or region claims goes to the external interface.
`ifndef MEMORY_MAP_REGS_VH
`define MEMORY_MAP_REGS_VH

// ----------------------------------------------------------------
// register map (byte offsets)
// ----------------------------------------------------------------
`define OFS_MODE_STATUS 4'h0
`define OFS_GLOBAL_ALLOC 4'h4
`define OFS_ARB_STATUS 4'h8

// processor_mode_status fields
`define BIT_MP_MODE 0
`define BIT_SINGLE_ACCESS_RAM_DATA_EN 1
`define BIT_SINGLE_ACCESS_RAM_PROG_EN 2
`define BIT_BLOCK0_PROG 3
`define RST_SINGLE_ACCESS_RAM_EN 1'b1
`define RST_BLOCK0_PROG 1'b0

// global_allocation_reg: bit 3 enables, bits 2:0 give size 256 << n
`define BIT_GLOBAL_EN 3
`define RST_GLOBAL_ALLOC 4'h0

// ----------------------------------------------------------------
// targets
// ----------------------------------------------------------------
`define PSEL_EXT 3'h0
`define PSEL_FLASH 3'h1
`define PSEL_SINGLE_ACCESS_RAM 3'h2
`define PSEL_BLOCK0 3'h3

`define DSEL_EXT 3'h0
`define DSEL_REGS 3'h1
`define DSEL_RESERVED 3'h2
`define DSEL_BLOCK2 3'h3
`define DSEL_BLOCK0 3'h4
`define DSEL_BLOCK1 3'h5
`define DSEL_SINGLE_ACCESS_RAM 3'h6
`define DSEL_GLOBAL 3'h7

`define ISEL_EXT 2'h0
`define ISEL_TEST 2'h1
`define ISEL_PERIPH 2'h2

// ----------------------------------------------------------------
// address map (word addresses)
// ----------------------------------------------------------------
`define D_REGS_TOP 16'h005F
`define D_B2_TOP 16'h007F
`define D_RSV_A_TOP 16'h00FF
`define D_B0_LO 16'h0100
`define D_B0_TOP 16'h02FF
`define D_B1_LO 16'h0300
`define D_B1_TOP 16'h04FF
`define D_RSV_B_TOP 16'h07FF
`define D_SINGLE_ACCESS_RAM_LO 16'h0800
`define D_SINGLE_ACCESS_RAM_TOP 16'h17FF
`define P_FLASH_TOP 16'h7FFF
`define P_SINGLE_ACCESS_RAM_LO 16'h8000
`define P_SINGLE_ACCESS_RAM_TOP 16'h8FFF
`define P_B0_LO 16'hFE00
`define I_TEST_LO 16'hFF00
`define I_TEST_TOP 16'hFF0F

`endif

// ===== memory_map_decoder.v
// memory map decoder: routes program, data and i/o addresses to on-chip blocks or outside
// assumes cpu address inputs come from logic on CLK_SYS_I; boot pin and grant are pins
`include "memory_map_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module memory_map_decoder (
	input wire CLK_SYS_I,
	input wire RST_I,
	input wire CE_I,
	// wishbone slave
	input wire CYC_I,
	input wire STB_I,
	input wire WE_I,
	input wire [3:0] ADR_I,
	input wire [3:0] SEL_I,
	input wire [31:0] DAT_I,
	output reg [31:0] DAT_O,
	output reg ACK_O,
	// pins
	input wire BOOT_MODE_PIN_I,
	input wire GLOBAL_BUS_GRANT_N_I,
	output reg GLOBAL_BUS_REQUEST_N_O,
	output reg MP_MODE_O,
	// program bus
	input wire PROG_REQ_I,
	input wire [15:0] PROG_ADDR_I,
	output reg PROG_VALID_O,
	output reg [2:0] PROG_SEL_O,
	output reg [15:0] PROG_OFFSET_O,
	// data bus
	input wire DATA_REQ_I,
	input wire [15:0] DATA_ADDR_I,
	output reg DATA_VALID_O,
	output reg [2:0] DATA_SEL_O,
	output reg [15:0] DATA_OFFSET_O,
	output reg DATA_WAIT_O,
	// i/o bus
	input wire IO_REQ_I,
	input wire [15:0] IO_ADDR_I,
	output reg IO_VALID_O,
	output reg [1:0] IO_SEL_O,
	output reg [15:0] IO_OFFSET_O
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg boot_meta_reg;
	reg boot_sync_reg;
	reg grant_meta_reg;
	reg grant_sync_reg;

	always @(posedge CLK_SYS_I) begin
		if (CE_I) begin
			boot_meta_reg <= BOOT_MODE_PIN_I;
			boot_sync_reg <= boot_meta_reg;
			grant_meta_reg <= GLOBAL_BUS_GRANT_N_I;
			grant_sync_reg <= grant_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	reg mp_mode_reg;
	reg single_access_ram_data_enable_reg;
	reg single_access_ram_program_enable_reg;
	reg block0_program_select_reg;
	reg [3:0] global_alloc_reg;
	reg [31:0] rd_next;

	wire wb_req = CYC_I & STB_I & ~ACK_O;
	wire wb_wr = wb_req & WE_I & SEL_I[0];

	always @* begin
		rd_next = 32'h0000_0000;
		case (ADR_I)
			`OFS_MODE_STATUS: begin
				rd_next[`BIT_MP_MODE] = mp_mode_reg;
				rd_next[`BIT_SINGLE_ACCESS_RAM_DATA_EN] = single_access_ram_data_enable_reg;
				rd_next[`BIT_SINGLE_ACCESS_RAM_PROG_EN] = single_access_ram_program_enable_reg;
				rd_next[`BIT_BLOCK0_PROG] = block0_program_select_reg;
			end
			`OFS_GLOBAL_ALLOC: begin
				rd_next[3:0] = global_alloc_reg;
			end
			`OFS_ARB_STATUS: begin
				rd_next[0] = ~GLOBAL_BUS_REQUEST_N_O;
				rd_next[1] = ~grant_sync_reg;
			end
			default: begin
				rd_next = 32'h0000_0000;
			end
		endcase
	end

	// reset holds the mode bit on the synchronised boot level, so the value
	// caught is the one standing when reset is released
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			mp_mode_reg <= boot_sync_reg; // see [RL7] see [RL8]
			single_access_ram_data_enable_reg <= `RST_SINGLE_ACCESS_RAM_EN; // see [RL5]
			single_access_ram_program_enable_reg <= `RST_SINGLE_ACCESS_RAM_EN;
			block0_program_select_reg <= `RST_BLOCK0_PROG;
			global_alloc_reg <= `RST_GLOBAL_ALLOC;
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else if (CE_I) begin
			ACK_O <= wb_req;
			if (wb_req) begin
				DAT_O <= rd_next;
			end
			if (wb_wr && ADR_I == `OFS_MODE_STATUS) begin
				mp_mode_reg <= DAT_I[`BIT_MP_MODE]; // see [RL8] see [RL9]
				single_access_ram_data_enable_reg <= DAT_I[`BIT_SINGLE_ACCESS_RAM_DATA_EN]; // see [RL5]
				single_access_ram_program_enable_reg <= DAT_I[`BIT_SINGLE_ACCESS_RAM_PROG_EN];
				block0_program_select_reg <= DAT_I[`BIT_BLOCK0_PROG];
			end
			if (wb_wr && ADR_I == `OFS_GLOBAL_ALLOC) begin
				global_alloc_reg <= DAT_I[3:0]; // see [RL2]
			end
		end
	end

	// ----------------------------------------------------------------
	// program space decode
	// ----------------------------------------------------------------
	reg [2:0] psel_next;
	reg [15:0] poff_next;

	always @* begin
		psel_next = `PSEL_EXT; // see [RL16]
		poff_next = PROG_ADDR_I;
		if (PROG_ADDR_I <= `P_FLASH_TOP) begin
			if (!mp_mode_reg) begin
				psel_next = `PSEL_FLASH; // see [RL9] see [RL15]
			end
		end else if (PROG_ADDR_I <= `P_SINGLE_ACCESS_RAM_TOP) begin
			if (single_access_ram_program_enable_reg) begin
				psel_next = `PSEL_SINGLE_ACCESS_RAM; // see [RL5] see [RL6]
				poff_next = PROG_ADDR_I - `P_SINGLE_ACCESS_RAM_LO;
			end
		end else if (PROG_ADDR_I >= `P_B0_LO) begin
			if (block0_program_select_reg) begin
				psel_next = `PSEL_BLOCK0; // see [RL12]
				poff_next = {8'h00, PROG_ADDR_I[7:0]}; // see [RL11]
			end
		end
	end

	// ----------------------------------------------------------------
	// data space decode
	// ----------------------------------------------------------------
	reg [2:0] dsel_next;
	reg [15:0] doff_next;
	reg [15:0] global_mask;
	reg global_hit;

	// size 256 << n: the region is every address whose bits above 7+n are all ones
	always @* begin
		global_mask = 16'hFF00 << global_alloc_reg[2:0];
		global_hit = global_alloc_reg[`BIT_GLOBAL_EN] &&
			((DATA_ADDR_I & global_mask) == global_mask); // see [RL2]
	end

	always @* begin
		dsel_next = `DSEL_EXT; // see [RL16]
		doff_next = DATA_ADDR_I;
		if (DATA_ADDR_I <= `D_REGS_TOP) begin
			dsel_next = `DSEL_REGS; // see [RL4]
		end else if (DATA_ADDR_I <= `D_B2_TOP) begin
			dsel_next = `DSEL_BLOCK2; // see [RL14]
			doff_next = {11'h000, DATA_ADDR_I[4:0]};
		end else if (DATA_ADDR_I <= `D_RSV_A_TOP) begin
			dsel_next = `DSEL_RESERVED;
		end else if (DATA_ADDR_I <= `D_B0_TOP) begin
			if (block0_program_select_reg) begin
				dsel_next = `DSEL_RESERVED;
			end else begin
				dsel_next = `DSEL_BLOCK0; // see [RL10]
				doff_next = {8'h00, DATA_ADDR_I[7:0]}; // see [RL11]
			end
		end else if (DATA_ADDR_I <= `D_B1_TOP) begin
			dsel_next = `DSEL_BLOCK1; // see [RL13]
			doff_next = {8'h00, DATA_ADDR_I[7:0]}; // see [RL11]
		end else if (DATA_ADDR_I <= `D_RSV_B_TOP) begin
			dsel_next = `DSEL_RESERVED;
		end else if (DATA_ADDR_I <= `D_SINGLE_ACCESS_RAM_TOP) begin
			if (single_access_ram_data_enable_reg) begin
				dsel_next = `DSEL_SINGLE_ACCESS_RAM; // see [RL5] see [RL6]
				doff_next = DATA_ADDR_I - `D_SINGLE_ACCESS_RAM_LO;
			end
		end
		// global wins over external only; on-chip blocks stay reachable
		if (dsel_next == `DSEL_EXT && global_hit) begin
			dsel_next = `DSEL_GLOBAL;
		end
	end

	// ----------------------------------------------------------------
	// i/o space decode
	// ----------------------------------------------------------------
	reg [1:0] isel_next;

	always @* begin
		isel_next = `ISEL_EXT; // see [RL16]
		if (IO_ADDR_I > `I_TEST_TOP) begin
			isel_next = `ISEL_PERIPH;
		end else if (IO_ADDR_I >= `I_TEST_LO) begin
			isel_next = `ISEL_TEST;
		end
	end

	// ----------------------------------------------------------------
	// global bus arbitration
	// ----------------------------------------------------------------
	// a global data access is held off until the grant is seen; the cpu must
	// keep its request and address steady while DATA_WAIT_O is high
	wire data_global = DATA_REQ_I && dsel_next == `DSEL_GLOBAL;
	wire granted = ~grant_sync_reg;

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			PROG_VALID_O <= 1'b0;
			PROG_SEL_O <= `PSEL_EXT;
			PROG_OFFSET_O <= 16'h0000;
			DATA_VALID_O <= 1'b0;
			DATA_SEL_O <= `DSEL_EXT;
			DATA_OFFSET_O <= 16'h0000;
			DATA_WAIT_O <= 1'b0;
			IO_VALID_O <= 1'b0;
			IO_SEL_O <= `ISEL_EXT;
			IO_OFFSET_O <= 16'h0000;
			GLOBAL_BUS_REQUEST_N_O <= 1'b1;
			MP_MODE_O <= 1'b0;
		end else if (CE_I) begin
			MP_MODE_O <= mp_mode_reg; // see [RL7]
			// each space decodes on its own request, in the same cycle
			PROG_VALID_O <= PROG_REQ_I; // see [RL1]
			PROG_SEL_O <= psel_next;
			PROG_OFFSET_O <= poff_next;
			IO_VALID_O <= IO_REQ_I;
			IO_SEL_O <= isel_next;
			IO_OFFSET_O <= IO_ADDR_I;
			DATA_SEL_O <= dsel_next;
			DATA_OFFSET_O <= doff_next;
			GLOBAL_BUS_REQUEST_N_O <= ~data_global; // see [RL3]
			if (data_global) begin
				DATA_VALID_O <= granted; // see [RL3]
				DATA_WAIT_O <= ~granted;
			end else begin
				DATA_VALID_O <= DATA_REQ_I;
				DATA_WAIT_O <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ===== mmd_props.sv
// checker for the memory map decoder ports
// assumes the bind below reaches every decoder instance
`include "memory_map_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module mmd_props (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	input wire logic MP_MODE_O,
	input wire logic PROG_REQ_I,
	input wire logic [15:0] PROG_ADDR_I,
	input wire logic PROG_VALID_O,
	input wire logic [2:0] PROG_SEL_O,
	input wire logic DATA_REQ_I,
	input wire logic [15:0] DATA_ADDR_I,
	input wire logic DATA_VALID_O,
	input wire logic [2:0] DATA_SEL_O,
	input wire logic [15:0] DATA_OFFSET_O,
	input wire logic DATA_WAIT_O,
	input wire logic GLOBAL_BUS_GRANT_N_I,
	input wire logic GLOBAL_BUS_REQUEST_N_O,
	input wire logic IO_REQ_I,
	input wire logic [15:0] IO_ADDR_I,
	input wire logic [1:0] IO_SEL_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	// grant held two edges: the synchroniser has it by now
	sequence s_granted;
		DATA_WAIT_O && !GLOBAL_BUS_GRANT_N_I ##1 !GLOBAL_BUS_GRANT_N_I;
	endsequence
	a_ack_next: assert property (CE_I && CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("ack late");
	a_ack_pulse: assert property (CE_I && ACK_O |=> !ACK_O)
		else $error("ack too long");
	a_regs_kept: assert property (CE_I && DATA_REQ_I && DATA_ADDR_I <= `D_REGS_TOP
		|=> DATA_SEL_O inside {`DSEL_REGS, `DSEL_RESERVED}) else $error("ram in regs");
	a_block2_map: assert property (CE_I && DATA_REQ_I && DATA_ADDR_I >= 16'h0060
		&& DATA_ADDR_I <= `D_B2_TOP |=> DATA_SEL_O == `DSEL_BLOCK2) else $error("b2 map");
	a_block1_alias: assert property (CE_I && DATA_REQ_I && DATA_ADDR_I >= `D_B1_LO
		&& DATA_ADDR_I <= `D_B1_TOP |=> DATA_SEL_O == `DSEL_BLOCK1
		&& DATA_OFFSET_O == ($past(DATA_ADDR_I) & 16'h00FF)) else $error("b1 map");
	a_prog_low: assert property (CE_I && PROG_REQ_I && PROG_ADDR_I <= `P_FLASH_TOP
		|=> $stable(MP_MODE_O) -> PROG_SEL_O == (MP_MODE_O ? `PSEL_EXT : `PSEL_FLASH))
		else $error("prog low map");
	a_prog_valid: assert property (CE_I && PROG_REQ_I |=> PROG_VALID_O)
		else $error("prog valid");
	a_io_test: assert property (CE_I && IO_REQ_I && IO_ADDR_I >= `I_TEST_LO
		&& IO_ADDR_I <= `I_TEST_TOP |=> IO_SEL_O == `ISEL_TEST) else $error("io test");
	a_wait_hold: assert property (DATA_WAIT_O |-> !DATA_VALID_O && !GLOBAL_BUS_REQUEST_N_O)
		else $error("wait");
	a_grant_done: assert property (s_granted |-> ##[0:4] !DATA_WAIT_O)
		else $error("grant lost");
endmodule
bind memory_map_decoder mmd_props chk_u (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
	.CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .MP_MODE_O(MP_MODE_O),
	.PROG_REQ_I(PROG_REQ_I), .PROG_ADDR_I(PROG_ADDR_I), .PROG_VALID_O(PROG_VALID_O),
	.PROG_SEL_O(PROG_SEL_O), .DATA_REQ_I(DATA_REQ_I), .DATA_ADDR_I(DATA_ADDR_I),
	.DATA_VALID_O(DATA_VALID_O), .DATA_SEL_O(DATA_SEL_O), .DATA_OFFSET_O(DATA_OFFSET_O),
	.DATA_WAIT_O(DATA_WAIT_O), .GLOBAL_BUS_GRANT_N_I(GLOBAL_BUS_GRANT_N_I),
	.GLOBAL_BUS_REQUEST_N_O(GLOBAL_BUS_REQUEST_N_O), .IO_REQ_I(IO_REQ_I),
	.IO_ADDR_I(IO_ADDR_I), .IO_SEL_O(IO_SEL_O));
`default_nettype wire

// ===== mmd_arbiter.sv
// global bus arbiter model on the far side of the request pin
// assumes request and grant are active low levels
`timescale 1ns/1ps
`default_nettype none
module mmd_arbiter #(parameter int DLY = 3) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_n_i,
	output logic grant_n_o
);
	int cnt;
	// late grant, so the decoder's wait path is really taken
	always @(posedge clk_i) begin
		if (rst_i || req_n_i) begin
			cnt <= 0;
			grant_n_o <= 1'b1;
		end else if (cnt == DLY) begin
			grant_n_o <= 1'b0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ===== memory_map_decoder_tb_top.sv
// self-checking bench for the memory map decoder
// assumes the arbiter model answers the global request pin
`include "memory_map_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder_tb_top;
	logic clk = 0, rst = 1, cyc = 0, we = 0, boot = 1, preq = 0, dreq = 0, ireq = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic [15:0] pa = 16'h0, da = 16'h0, ia = 16'h0;
	wire logic ack, reqn, gntn, mp, pv, dv, dw, iv;
	wire logic [31:0] dato;
	wire logic [2:0] ps, ds;
	wire logic [1:0] isl;
	wire logic [15:0] po, dof, io;
	int n_mismatch = 0, compares = 0;
	always #4 clk = ~clk;
	memory_map_decoder dut_u (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1), .CYC_I(cyc),
		.STB_I(cyc), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(dato),
		.ACK_O(ack), .BOOT_MODE_PIN_I(boot), .GLOBAL_BUS_GRANT_N_I(gntn),
		.GLOBAL_BUS_REQUEST_N_O(reqn), .MP_MODE_O(mp), .PROG_REQ_I(preq), .PROG_ADDR_I(pa),
		.PROG_VALID_O(pv), .PROG_SEL_O(ps), .PROG_OFFSET_O(po), .DATA_REQ_I(dreq),
		.DATA_ADDR_I(da), .DATA_VALID_O(dv), .DATA_SEL_O(ds), .DATA_OFFSET_O(dof),
		.DATA_WAIT_O(dw), .IO_REQ_I(ireq), .IO_ADDR_I(ia), .IO_VALID_O(iv), .IO_SEL_O(isl),
		.IO_OFFSET_O(io));
	mmd_arbiter arb_u (.clk_i(clk), .rst_i(rst), .req_n_i(reqn), .grant_n_o(gntn));
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rdat = dato;
		cyc <= 1'b0;
	endtask
	// sp: 0 program, 1 data, 2 i/o; a data access may wait for grant
	task automatic pr(input int sp, input logic [15:0] a, input logic [2:0] s,
		input logic [15:0] o);
		@(posedge clk);
		preq <= (sp == 0); dreq <= (sp == 1); ireq <= (sp == 2);
		pa <= a; da <= a; ia <= a;
		@(posedge clk);
		#1;
		for (int k = 0; k < 20 && sp == 1 && dv !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		chk(sp == 0 ? {pv, ps, po} : sp == 1 ? {dv, ds, dof} : {iv, 1'b0, isl, io}, {1'b1, s, o});
		preq <= 1'b0; dreq <= 1'b0; ireq <= 1'b0;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk(mp, 1);
		pr(0, 16'h0000, `PSEL_EXT, 16'h0000);
		wb(0, `OFS_MODE_STATUS, 0);
		chk(rdat, 32'h7);
		pr(1, 16'h0060, `DSEL_BLOCK2, 16'h0000);
		pr(1, 16'h0105, `DSEL_BLOCK0, 16'h0005);
		pr(1, 16'h0205, `DSEL_BLOCK0, 16'h0005);
		pr(1, 16'h04FF, `DSEL_BLOCK1, 16'h00FF);
		pr(1, 16'h17FF, `DSEL_SINGLE_ACCESS_RAM, 16'h0FFF);
		pr(1, 16'h1800, `DSEL_EXT, 16'h1800);
		pr(0, 16'h0105, `PSEL_EXT, 16'h0105);
		pr(2, 16'hFF05, `ISEL_TEST, 16'hFF05);
		pr(2, 16'h0010, `ISEL_EXT, 16'h0010);
		$display("test map done");
		wb(1, `OFS_MODE_STATUS, 32'h8);
		pr(0, 16'h0000, `PSEL_FLASH, 16'h0000);
		pr(0, 16'hFE05, `PSEL_BLOCK0, 16'h0005);
		pr(0, 16'hFF05, `PSEL_BLOCK0, 16'h0005);
		pr(1, 16'h0105, `DSEL_RESERVED, 16'h0105);
		pr(1, 16'h0800, `DSEL_EXT, 16'h0800);
		pr(0, 16'h8000, `PSEL_EXT, 16'h8000);
		wb(0, `OFS_MODE_STATUS, 0);
		chk(rdat, 32'h8);
		wb(1, `OFS_MODE_STATUS, 32'h6);
		pr(0, 16'h8FFF, `PSEL_SINGLE_ACCESS_RAM, 16'h0FFF);
		pr(0, 16'hFE05, `PSEL_EXT, 16'hFE05);
		wb(0, 4'hC, 0);
		chk(rdat, 32'h0);
		$display("test mode done");
		wb(1, `OFS_GLOBAL_ALLOC, 32'h8);
		pr(1, 16'hFF10, `DSEL_GLOBAL, 16'hFF10);
		pr(1, 16'hFEFF, `DSEL_EXT, 16'hFEFF);
		wb(1, `OFS_GLOBAL_ALLOC, 32'hF);
		pr(1, 16'h8000, `DSEL_GLOBAL, 16'h8000);
		pr(1, 16'h7FFF, `DSEL_EXT, 16'h7FFF);
		$display("test global done");
		rst <= 1'b1; boot <= 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		pr(0, 16'h0000, `PSEL_FLASH, 16'h0000);
		chk(mp, 0);
		$display("test reboot done");
		give_verdict;
	end
endmodule
`default_nettype wire
